// >>> logic/asf_pkg.sv
/*
 * Constants, types and shared decode functions for the async serial frame engine.
 * Assumes one 40 MHz system clock and a 16-bit register port with byte offsets.
 */
package asf_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFF_BAUD   = 8'h00;
    localparam logic [7:0]  OFF_TXBUF  = 8'h04;
    localparam logic [7:0]  OFF_RXBUF  = 8'h08;
    localparam logic [7:0]  OFF_CTRL   = 8'h0c;
    localparam logic [7:0]  OFF_STATUS = 8'h14;
    // Control word fields
    localparam int          CTL_MODE_LO = 0;
    localparam int          CTL_STOP_LO = 3;
    localparam int          CTL_ODD     = 5;
    localparam int          CTL_LOOP    = 6;
    localparam int          CTL_RUN     = 7;
    localparam int          CTL_RXEN    = 8;
    localparam logic [8:0]  CTL_RESET   = 9'h000;
    // Status word fields
    localparam int          ST_RXFULL  = 0;
    localparam int          ST_DRAINED = 1;
    localparam int          ST_TXFREE  = 2;
    localparam int          ST_PARERR  = 3;
    localparam int          ST_FRMERR  = 4;
    localparam int          ST_OVERRUN = 5;
    // Frame mode codes
    localparam logic [2:0]  MODE_8   = 3'h1;
    localparam logic [2:0]  MODE_7P  = 3'h3;
    localparam logic [2:0]  MODE_9   = 3'h4;
    localparam logic [2:0]  MODE_8W  = 3'h5;
    localparam logic [2:0]  MODE_8P  = 3'h7;
    // Stop length codes
    localparam logic [1:0]  STOP_HALF    = 2'h0;
    localparam logic [1:0]  STOP_ONE     = 2'h1;
    localparam logic [1:0]  STOP_ONEHALF = 2'h2;
    localparam logic [1:0]  STOP_TWO     = 2'h3;
    // Oversampling timing in ticks
    localparam logic [5:0]  TICKS_BIT     = 6'h10;
    localparam logic [3:0]  DIV_LAST      = 4'hf;
    localparam logic [5:0]  VOTE_START    = 6'h03;
    localparam logic [5:0]  VOTE_DATA     = 6'h09;
    localparam logic [5:0]  VOTE_HALF     = 6'h05;
    localparam logic [5:0]  VOTE_ONE      = 6'h09;
    localparam logic [5:0]  VOTE_ONEHALF  = 6'h11;
    localparam logic [5:0]  VOTE_SECOND   = 6'h19;
    localparam logic [5:0]  TICKS_HALF    = 6'h08;
    localparam logic [5:0]  TICKS_ONEHALF = 6'h18;
    localparam logic [5:0]  TICKS_TWO     = 6'h20;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_WAIT  = 3'h1,
        TX_START = 3'h3,
        TX_DATA  = 3'h2,
        TX_STOP  = 3'h6
    } asf_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3,
        RX_STOP  = 2'h2
    } asf_rx_state_type;

    // Parity bit; even sets it on an odd count of ones
    function automatic logic asf_parity(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction : asf_parity

    // Data field length including parity or wake bit
    function automatic logic [3:0] asf_nbits(input logic [2:0] mode);
        return mode[2] ? 4'h9 : 4'h8;
    endfunction : asf_nbits

    // Stop period length in ticks
    function automatic logic [5:0] asf_stop_ticks(input logic [1:0] sel);
        case (sel)
            STOP_HALF:    return TICKS_HALF;
            STOP_ONE:     return TICKS_BIT;
            STOP_ONEHALF: return TICKS_ONEHALF;
            default:      return TICKS_TWO;
        endcase
    endfunction : asf_stop_ticks

    function automatic logic asf_maj(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : asf_maj
endpackage : asf_pkg

// >>> logic/asf_frame_engine.sv
/*
 * Async serial frame engine: baud tick, transmit and receive datapaths, registers.
 * Assumes rxd is already synchronous to clk_sys and a bus master that never waits.
 */
module asf_frame_engine (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [15:0] regRdData,
    input  wire logic        rxd,
    output logic             txd
);
    import asf_pkg::*;

    typedef struct packed {
        logic [8:0]       ctrl;
        logic [15:0]      reload;
        logic [15:0]      timer;
        logic             reloadPend;
        logic [3:0]       divCnt;
        asf_tx_state_type txState;
        logic [5:0]       txCnt;
        logic [3:0]       txBit;
        logic [8:0]       txShift;
        logic             txLine;
        logic [8:0]       txHold;
        logic             holdValid;
        logic             bufFree;
        logic             drained;
        asf_rx_state_type rxState;
        logic [5:0]       rxCnt;
        logic [3:0]       rxBit;
        logic [1:0]       rxSmp;
        logic [9:0]       rxShift;
        logic             rxFrameBad;
        logic [9:0]       rxEntry;
        logic             rxEntryPar;
        logic             rxFull;
        logic             overrun;
        logic [15:0]      rdData;
    } asf_state_type;

    asf_state_type st_r;
    asf_state_type st_nxt;

    logic       run;
    logic       tick;
    logic       divOvf;
    logic       rxIn;
    logic       rdRx;
    logic       rxDone;
    logic [2:0] mode;
    logic [1:0] stopSel;
    logic       oddSel;
    logic       vote3;

    // Baud tick only while running, so clearing run freezes both engines
    assign run     = st_r.ctrl[CTL_RUN];
    assign tick    = run && (st_r.timer == 16'h0000);
    assign divOvf  = tick && (st_r.divCnt == DIV_LAST);
    assign mode    = st_r.ctrl[CTL_MODE_LO +: 3];
    assign stopSel = st_r.ctrl[CTL_STOP_LO +: 2];
    assign oddSel  = st_r.ctrl[CTL_ODD];
    assign rxIn    = st_r.ctrl[CTL_LOOP] ? st_r.txLine : rxd;
    assign rdRx    = regRdEn && (regAddr == OFF_RXBUF);
    // Idle line is high whenever the generator is stopped
    assign txd       = run ? st_r.txLine : 1'b1;
    assign regRdData = st_r.rdData;
    assign vote3     = asf_maj(st_r.rxSmp[1], st_r.rxSmp[0], rxIn);

    // Shifter word; parity is made here so software never computes it
    function automatic logic [8:0] asf_tx_word(input logic [8:0] hold, input logic [2:0] md,
                                               input logic odd);
        case (md)
            MODE_7P: return {1'b0, asf_parity({1'b0, hold[6:0]}, odd), hold[6:0]};
            MODE_8P: return {asf_parity(hold[7:0], odd), hold[7:0]};
            default: return hold;
        endcase
    endfunction : asf_tx_word

    // Whole next-state computation
    always_comb begin
        logic [5:0] tc;
        logic [5:0] rc;
        logic       vote;
        logic [8:0] d9;
        logic       bit8;
        tc     = st_r.txCnt + 6'h01;
        rc     = st_r.rxCnt + 6'h01;
        vote   = asf_maj(st_r.rxSmp[1], st_r.rxSmp[0], rxIn);
        d9     = 9'h000;
        bit8   = 1'b0;
        rxDone = 1'b0;
        st_nxt = st_r;
        st_nxt.rdData = 16'h0000;

        // Reload timer; a pending write lands once run is set
        if (run) begin
            if (st_r.reloadPend) begin
                st_nxt.timer      = st_r.reload;
                st_nxt.reloadPend = 1'b0;
            end else if (tick) begin
                st_nxt.timer = st_r.reload;
            end else begin
                st_nxt.timer = st_r.timer - 16'h0001;
            end
        end
        if (tick) begin
            st_nxt.divCnt = st_r.divCnt + 4'h1;
        end

        // Transmitter
        case (st_r.txState)
            TX_IDLE: begin
                st_nxt.txLine = 1'b1;
                if (run && st_r.holdValid) begin
                    st_nxt.txShift   = asf_tx_word(st_r.txHold, mode, oddSel);
                    st_nxt.holdValid = 1'b0;
                    st_nxt.bufFree   = 1'b1;
                    st_nxt.txState   = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (divOvf) begin
                    st_nxt.txState = TX_START;
                    st_nxt.txLine  = 1'b0;
                    st_nxt.txCnt   = 6'h00;
                end
            end
            TX_START: begin
                if (tick) begin
                    st_nxt.txCnt = tc;
                    if (tc == TICKS_BIT) begin
                        st_nxt.txState = TX_DATA;
                        st_nxt.txLine  = st_r.txShift[0];
                        st_nxt.txCnt   = 6'h00;
                        st_nxt.txBit   = 4'h0;
                    end
                end
            end
            TX_DATA: begin
                if (tick) begin
                    st_nxt.txCnt = tc;
                    if (tc == TICKS_BIT) begin
                        st_nxt.txCnt = 6'h00;
                        if (st_r.txBit == asf_nbits(mode) - 4'h1) begin
                            st_nxt.txState = TX_STOP;
                            st_nxt.txLine  = 1'b1;
                            st_nxt.drained = 1'b1;
                        end else begin
                            st_nxt.txBit   = st_r.txBit + 4'h1;
                            st_nxt.txShift = st_r.txShift >> 1;
                            st_nxt.txLine  = st_r.txShift[1];
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tick) begin
                    st_nxt.txCnt = tc;
                    if (tc == asf_stop_ticks(stopSel)) begin
                        st_nxt.txState = TX_IDLE;
                        if (st_r.holdValid) begin
                            st_nxt.txShift   = asf_tx_word(st_r.txHold, mode, oddSel);
                            st_nxt.holdValid = 1'b0;
                            st_nxt.bufFree   = 1'b1;
                            st_nxt.txState   = TX_WAIT;
                        end
                    end
                end
            end
            default: begin
                st_nxt.txState = TX_IDLE;
            end
        endcase

        // Receiver; all progress waits on the oversampling tick
        if (tick) begin
            st_nxt.rxSmp = {st_r.rxSmp[0], rxIn};
        end
        case (st_r.rxState)
            RX_IDLE: begin
                // Edge counts as sample one of the start bit
                if (tick && st_r.ctrl[CTL_RXEN] && st_r.rxSmp[0] && !rxIn) begin
                    st_nxt.rxState    = RX_START;
                    st_nxt.rxCnt      = 6'h01;
                    st_nxt.rxFrameBad = 1'b0;
                end
            end
            RX_START: begin
                if (tick) begin
                    st_nxt.rxCnt = rc;
                    if (rc == VOTE_START && vote) begin
                        st_nxt.rxState = RX_IDLE;
                    end else if (rc == TICKS_BIT) begin
                        st_nxt.rxState = RX_DATA;
                        st_nxt.rxCnt   = 6'h00;
                        st_nxt.rxBit   = 4'h0;
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    st_nxt.rxCnt = rc;
                    if (rc == VOTE_DATA) begin
                        st_nxt.rxShift = {vote, st_r.rxShift[9:1]};
                    end
                    if (rc == TICKS_BIT) begin
                        st_nxt.rxCnt = 6'h00;
                        st_nxt.rxBit = st_r.rxBit + 4'h1;
                        if (st_r.rxBit == asf_nbits(mode) - 4'h1) begin
                            st_nxt.rxState = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP: begin
                if (tick) begin
                    st_nxt.rxCnt = rc;
                    // Vote windows differ with the programmed stop length
                    if ((stopSel == STOP_HALF && rc == VOTE_HALF) ||
                        ((stopSel == STOP_ONE || stopSel == STOP_TWO) && rc == VOTE_ONE) ||
                        (stopSel == STOP_ONEHALF && rc == VOTE_ONEHALF) ||
                        (stopSel == STOP_TWO && rc == VOTE_SECOND)) begin
                        st_nxt.rxFrameBad = st_r.rxFrameBad | !vote;
                    end
                    if (rc == asf_stop_ticks(stopSel)) begin
                        st_nxt.rxState = RX_IDLE;
                        rxDone         = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt.rxState = RX_IDLE;
            end
        endcase

        // Reading the buffer releases it; a same-cycle arrival still wins below
        if (rdRx) begin
            st_nxt.rxFull  = 1'b0;
            st_nxt.overrun = 1'b0;
        end

        // Frame hand-over into the receive buffer
        if (rxDone) begin
            d9 = asf_nbits(mode) == 4'h9 ? st_r.rxShift[9:1] : {1'b0, st_r.rxShift[9:2]};
            case (mode)
                MODE_7P: bit8 = d9[7] ^ asf_parity({1'b0, d9[6:0]}, oddSel);
                MODE_8P: bit8 = d9[8] ^ asf_parity(d9[7:0], oddSel);
                default: bit8 = d9[8];
            endcase
            // Wake mode drops data frames without any trace
            if (!(mode == MODE_8W && !d9[8])) begin
                if (st_r.rxFull && !rdRx) begin
                    st_nxt.overrun = 1'b1;
                end
                st_nxt.rxEntry    = {st_r.rxFrameBad, bit8, d9[7:0]};
                st_nxt.rxEntryPar = (mode == MODE_7P) || (mode == MODE_8P);
                st_nxt.rxFull     = 1'b1;
            end
        end

        // Register writes
        if (regWrEn) begin
            case (regAddr)
                OFF_CTRL: begin
                    st_nxt.ctrl = regWrData[8:0];
                end
                OFF_BAUD: begin
                    st_nxt.reload = regWrData;
                    if (run) begin
                        st_nxt.timer = regWrData;
                    end else begin
                        st_nxt.reloadPend = 1'b1;
                    end
                end
                OFF_TXBUF: begin
                    // Later write wins over a same-cycle move into the shifter
                    st_nxt.txHold    = regWrData[8:0];
                    st_nxt.holdValid = 1'b1;
                    st_nxt.bufFree   = 1'b0;
                    st_nxt.drained   = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped offsets return zero
        if (regRdEn) begin
            case (regAddr)
                OFF_BAUD:   st_nxt.rdData = st_r.timer;
                OFF_RXBUF:  st_nxt.rdData = {7'h00, st_r.rxEntry[8:0]};
                OFF_CTRL:   st_nxt.rdData = {7'h00, st_r.ctrl};
                OFF_STATUS: begin
                    st_nxt.rdData[ST_RXFULL]  = st_r.rxFull;
                    st_nxt.rdData[ST_DRAINED] = st_r.drained;
                    st_nxt.rdData[ST_TXFREE]  = st_r.bufFree;
                    st_nxt.rdData[ST_PARERR]  = st_r.rxFull && st_r.rxEntryPar
                                                && st_r.rxEntry[8];
                    st_nxt.rdData[ST_FRMERR]  = st_r.rxFull && st_r.rxEntry[9];
                    st_nxt.rdData[ST_OVERRUN] = st_r.overrun;
                end
                default:    st_nxt.rdData = 16'h0000;
            endcase
        end
    end

    // State register; reset leaves engines idle, receive flags clear, buffer-free and drained flags set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r           <= '0;
            st_r.txLine    <= 1'b1;
            st_r.bufFree   <= 1'b1;
            st_r.drained   <= 1'b1;
            st_r.rxSmp     <= 2'h3;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Engine checks; all quiet while reset is held

    rxbuf_upper_zero_a: assert property (
        $past(rdRx) |-> regRdData[15:9] == 7'h00)
        else $error("receive buffer upper bits not zero");
    overrun_on_full_a: assert property (
        (rxDone && st_r.rxFull && !rdRx && !(mode == MODE_8W)) |=> st_r.overrun && st_r.rxFull)
        else $error("overrun not flagged");
    loopback_path_a: assert property (
        (st_r.ctrl[CTL_LOOP] && st_r.ctrl[CTL_RXEN] && st_r.rxState == RX_IDLE && tick
         && st_r.rxSmp[0] && !st_r.txLine) |=> st_r.rxState == RX_START)
        else $error("loopback path broken");
    tx_start_ovf_a: assert property (
        (st_r.txState == TX_WAIT && divOvf) |=> st_r.txState == TX_START && !txd)
        else $error("start bit not on divider overflow");
    tx_idle_load_a: assert property (
        (st_r.txState == TX_IDLE && run && st_r.holdValid) |=>
        st_r.txState == TX_WAIT && (st_r.bufFree || st_r.holdValid))
        else $error("idle load did not free buffer");
    tx_parity_gen_a: assert property (
        (st_r.txState == TX_IDLE && run && st_r.holdValid && mode == MODE_7P && !regWrEn) |=>
        st_r.txShift[7] == ((^st_r.txShift[6:0]) ^ oddSel))
        else $error("transmit parity bit wrong");
    tx_parity9_a: assert property (
        (st_r.txState == TX_IDLE && run && st_r.holdValid && mode == MODE_8P && !regWrEn) |=>
        st_r.txShift[8] == ((^st_r.txShift[7:0]) ^ oddSel))
        else $error("transmit ninth-bit parity wrong");
    drained_first_stop_a: assert property (
        (st_r.txState == TX_STOP && $past(st_r.txState) == TX_DATA) |-> st_r.drained && txd)
        else $error("drained flag late at first stop");
    rx_disabled_idle_a: assert property (
        (st_r.rxState == RX_IDLE && !st_r.ctrl[CTL_RXEN]) |=> st_r.rxState == RX_IDLE)
        else $error("receiver started while disabled");
    freeze_on_stop_a: assert property (
        (!run && !regWrEn) |=> $stable(st_r.txState) && $stable(st_r.rxState))
        else $error("engine moved while stopped");
    read_clears_a: assert property (
        (rdRx && !rxDone) |=> !st_r.rxFull && !st_r.overrun)
        else $error("read did not clear flags");
    start_reject_a: assert property (
        (st_r.rxState == RX_START && tick && st_r.rxCnt == 6'h02 && vote3) |=>
        st_r.rxState == RX_IDLE)
        else $error("false start not rejected");

    tx_frame_c:   cover property (st_r.txState == TX_STOP ##1 st_r.txState == TX_IDLE);
    rx_frame_c:   cover property (rxDone && st_r.rxState == RX_STOP);
    overrun_c:    cover property (!st_r.overrun ##1 st_r.overrun);
    wake_drop_c:  cover property (rxDone && mode == MODE_8W && !st_r.rxShift[9]);
    tx_parity_c:  cover property (st_r.txState == TX_WAIT && mode == MODE_7P);
endmodule : asf_frame_engine

// >>> dv/asf_serial_peer.sv
/*
 * Remote serial peer: sends frames on rxd and decodes frames seen on txd.
 * Assumes the baud reload is 0, so one tick per clock and 16 clocks per bit.
 */
module asf_serial_peer (
    input  wire logic       clk_sys,
    input  wire logic       txd,
    input  wire logic [3:0] frameBits,
    output logic            rxd
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [8:0] lastFrame;
    logic [8:0] cap;
    int         frameCount;

    // Line idles high, as with a pull-up
    initial begin
        rxd = 1'b1;
        lastFrame = '0;
        frameCount = 0;
    end

    // Start bit, field LSB first, then stop level for the given ticks
    task automatic sendFrame(input logic [8:0] bits, input int nb, input int stopTicks,
                             input logic badStop);
        @(posedge clk_sys);
        rxd <= 1'b0;
        repeat (16) @(posedge clk_sys);
        for (int i = 0; i < nb; i++) begin
            rxd <= bits[i];
            repeat (16) @(posedge clk_sys);
        end
        rxd <= ~badStop;
        repeat (stopTicks) @(posedge clk_sys);
        rxd <= 1'b1;
    endtask : sendFrame

    // One-clock low pulse, too short to win the start vote
    task automatic glitch();
        @(posedge clk_sys);
        rxd <= 1'b0;
        @(posedge clk_sys);
        rxd <= 1'b1;
    endtask : glitch

    // Sample txd mid-bit; count bumps a few clocks into the stop bit
    initial forever begin
        @(posedge clk_sys);
        if (txd === 1'b0) begin
            cap = '0;
            repeat (8) @(posedge clk_sys);
            for (int i = 0; i < int'(frameBits); i++) begin
                repeat (16) @(posedge clk_sys);
                cap[i] = txd;
            end
            repeat (12) @(posedge clk_sys);
            lastFrame = cap;
            frameCount++;
        end
    end
endmodule : asf_serial_peer

// >>> dv/tb_async_serial_frame_engine.sv
/*
 * Self-checking bench: table of frame formats echoed through the peer, then edge cases.
 * Assumes the register map and status layout of the package and a 40 MHz clock.
 */
module tb_async_serial_frame_engine;
    timeunit 1ns;
    timeprecision 100ps;
    import asf_pkg::*;

    typedef struct {
        logic [2:0]  mode;
        logic        odd;
        logic [1:0]  stop;
        logic [8:0]  tx;
        logic [8:0]  line;
        logic [15:0] mask;
        logic [15:0] rx;
    } asf_row_type;

    // Written data, expected line field, expected receive buffer
    asf_row_type rows [7] = '{
        '{MODE_8,  1'b0, STOP_ONE,     9'h0a5, 9'h0a5, 16'hfeff, 16'h00a5},
        '{MODE_7P, 1'b0, STOP_HALF,    9'h013, 9'h093, 16'hffff, 16'h0093},
        '{MODE_7P, 1'b1, STOP_ONEHALF, 9'h013, 9'h013, 16'hffff, 16'h0013},
        '{MODE_8P, 1'b0, STOP_TWO,     9'h001, 9'h101, 16'hffff, 16'h0001},
        '{MODE_8P, 1'b1, STOP_ONE,     9'h003, 9'h103, 16'hffff, 16'h0003},
        '{MODE_9,  1'b0, STOP_ONE,     9'h1c3, 9'h1c3, 16'hffff, 16'h01c3},
        '{MODE_8W, 1'b0, STOP_HALF,    9'h15a, 9'h15a, 16'hffff, 16'h015a}
    };

    logic        clk_sys;
    logic        rst;
    logic [7:0]  regAddr;
    logic [15:0] regWrData;
    logic        regWrEn;
    logic        regRdEn;
    logic [15:0] regRdData;
    logic        rxd;
    logic        txd;
    logic [3:0]  peerBits;
    int          mismatches;
    int          testsRun;

    asf_frame_engine dut (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWrEn   (regWrEn),
        .regRdEn   (regRdEn),
        .regRdData (regRdData),
        .rxd       (rxd),
        .txd       (txd)
    );

    asf_serial_peer peer (
        .clk_sys   (clk_sys),
        .txd       (txd),
        .frameBits (peerBits),
        .rxd       (rxd)
    );

    // 25 ns period
    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask : wrReg

    // Data stands only in the cycle after the strobe
    task automatic rdCheck(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        check(regRdData & m, e);
    endtask : rdCheck

    // Bounded wait for the peer to decode frame number n
    task automatic waitFrame(input int n);
        for (int k = 0; k < 800 && peer.frameCount < n; k++) @(posedge clk_sys);
        check(16'(peer.frameCount), 16'(n));
    endtask : waitFrame

    // Peer sends one frame with one stop bit; status compared after
    task automatic rxCase(input logic [15:0] ctl, input logic [8:0] bits, input logic bad,
                          input logic [15:0] st);
        wrReg(OFF_CTRL, ctl);
        peer.sendFrame(bits, ctl[2] ? 9 : 8, 16, bad);
        repeat (4) @(posedge clk_sys);
        rdCheck(OFF_STATUS, 16'hffff, st);
    endtask : rxCase

    // Hang guard, well beyond the expected few thousand cycles
    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        peerBits = 4'h8;
        mismatches = 0;
        testsRun = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rdCheck(OFF_STATUS, 16'hffff, 16'h0006);
        rdCheck(OFF_CTRL, 16'hffff, 16'h0000);
        rdCheck(8'h1c, 16'hffff, 16'h0000);
        check({15'h0000, txd}, 16'h0001);
        wrReg(OFF_BAUD, 16'h0000);
        // Send each format out, echo it back, read it in
        foreach (rows[i]) begin
            peerBits = rows[i].mode[2] ? 4'h9 : 4'h8;
            wrReg(OFF_CTRL, {7'h00, 2'b11, 1'b0, rows[i].odd, rows[i].stop, rows[i].mode});
            wrReg(OFF_TXBUF, {7'h00, rows[i].tx});
            repeat (2) @(posedge clk_sys);
            rdCheck(OFF_STATUS, 16'hffff, 16'h0004);
            waitFrame(i + 1);
            rdCheck(OFF_STATUS, 16'hffff, 16'h0006);
            check({7'h00, peer.lastFrame}, {7'h00, rows[i].line});
            peer.sendFrame(rows[i].line, int'(peerBits), (int'(rows[i].stop) + 1) * 8, 1'b0);
            repeat (4) @(posedge clk_sys);
            rdCheck(OFF_STATUS, 16'hffff, 16'h0007);
            rdCheck(OFF_RXBUF, rows[i].mask, rows[i].rx);
            rdCheck(OFF_STATUS, 16'hffff, 16'h0006);
        end
        // Parity mismatch recorded in entry bit 8
        rxCase(16'h018f, 9'h001, 1'b0, 16'h000f);
        rdCheck(OFF_RXBUF, 16'hffff, 16'h0101);
        // Low stop bit still completes the frame
        rxCase(16'h0189, 9'h055, 1'b1, 16'h0017);
        rdCheck(OFF_RXBUF, 16'hfeff, 16'h0055);
        rdCheck(OFF_STATUS, 16'hffff, 16'h0006);
        // Second frame before a read overwrites the first
        rxCase(16'h0189, 9'h011, 1'b0, 16'h0007);
        rxCase(16'h0189, 9'h022, 1'b0, 16'h0027);
        rdCheck(OFF_RXBUF, 16'hfeff, 16'h0022);
        // Address filter drops frames with ninth bit low
        rxCase(16'h018d, 9'h05a, 1'b0, 16'h0006);
        rxCase(16'h018d, 9'h1a5, 1'b0, 16'h0007);
        rdCheck(OFF_RXBUF, 16'hffff, 16'h01a5);
        // Short low pulse must not start a frame
        peer.glitch();
        repeat (300) @(posedge clk_sys);
        rdCheck(OFF_STATUS, 16'hffff, 16'h0006);
        // Receiver switched off mid-frame finishes that frame only
        wrReg(OFF_CTRL, 16'h0189);
        fork
            peer.sendFrame(9'h0c3, 8, 16, 1'b0);
            begin
                repeat (60) @(posedge clk_sys);
                wrReg(OFF_CTRL, 16'h0089);
            end
        join
        repeat (4) @(posedge clk_sys);
        rdCheck(OFF_STATUS, 16'hffff, 16'h0007);
        rdCheck(OFF_RXBUF, 16'hfeff, 16'h00c3);
        rxCase(16'h0089, 9'h0aa, 1'b0, 16'h0006);
        // Loopback carries the transmitted frame into the receiver
        peerBits = 4'h8;
        wrReg(OFF_CTRL, 16'h01c9);
        wrReg(OFF_TXBUF, 16'h003c);
        waitFrame(8);
        repeat (20) @(posedge clk_sys);
        rdCheck(OFF_RXBUF, 16'hfeff, 16'h003c);
        finish_test();
    end
endmodule : tb_async_serial_frame_engine
